// ### dac_ctrl_pkg.sv
// shared constants for the dac toggle, monitor and thermal control block
package dac_ctrl_pkg;

  // ----------------------------------------------------------------
  // array geometry
  // ----------------------------------------------------------------
  localparam int NUM_CH     = 40;
  localparam int CH_W       = 6;
  localparam int SEL_W      = 2;
  localparam int CODE_W     = 14;
  localparam int GROUP_SZ   = 8;
  localparam int NUM_GROUPS = 5;

  // ----------------------------------------------------------------
  // register select codes (upper two address bits)
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] SEL_CTRL = 2'h0;
  localparam logic [SEL_W-1:0] SEL_B    = 2'h2;
  localparam logic [SEL_W-1:0] SEL_A    = 2'h3;

  // ----------------------------------------------------------------
  // channel addresses used with the control select
  // ----------------------------------------------------------------
  localparam logic [CH_W-1:0] ADDR_PWRUP = 6'h09;
  localparam logic [CH_W-1:0] ADDR_MON   = 6'h0a;
  localparam logic [CH_W-1:0] ADDR_CTRL  = 6'h0c;
  localparam logic [CH_W-1:0] ADDR_STAT  = 6'h0d;
  localparam logic [CH_W-1:0] ADDR_MASK  = 6'h0e;
  localparam logic [CH_W-1:0] MON_OFF    = 6'h3f;
  localparam logic [CH_W-1:0] CH_LIMIT   = 6'h28;

  // ----------------------------------------------------------------
  // control register fields and reset value
  // ----------------------------------------------------------------
  localparam int CR_TOG_LO = 2;
  localparam int CR_TOG_HI = 6;
  localparam int CR_THERM  = 8;
  localparam int CR_MON    = 9;
  localparam logic [CODE_W-1:0] CTRL_RST = 14'h0000;
  localparam logic [CODE_W-1:0] CODE_RST = 14'h0000;

  // ----------------------------------------------------------------
  // interrupt status and mask layout
  // ----------------------------------------------------------------
  localparam int IRQ_W     = 2;
  localparam int IRQ_THERM = 0;
  localparam int IRQ_BREJ  = 1;
  localparam logic [IRQ_W-1:0] MASK_RST = 2'h0;

  // amplifier guard states
  typedef enum logic [1:0] {
    AMP_RUN  = 2'b01,
    AMP_SHUT = 2'b10
  } amp_state_t;

endpackage

// ### thermal_if.sv
// carrier between the control core and the thermal guard
`timescale 1ns/1ns
interface thermal_if;
  logic guard_en;
  logic over_temp;
  logic pwrup;
  logic amp_on;
  logic shut_evt;

  modport ctl   (output guard_en, output over_temp, output pwrup,
                 input amp_on, input shut_evt);
  modport guard (input guard_en, input over_temp, input pwrup,
                 output amp_on, output shut_evt);
endinterface

// ### thermal_guard.sv
// thermal guard: powers amplifiers down on over-temperature
`timescale 1ns/1ns
module thermal_guard
  import dac_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // link to control core
  thermal_if.guard  tif
);

  amp_state_t state_r;
  amp_state_t state_nxt;
  logic       evt_r;
  logic       evt_nxt;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    evt_nxt   = 1'b0;
    unique case (state_r)
      AMP_RUN: begin
        // (RL11) trip on heat
        if (tif.guard_en && tif.over_temp) begin
          state_nxt = AMP_SHUT;
          evt_nxt   = 1'b1;
        end
      end
      AMP_SHUT: begin
        // (RL12) leave only via disable or cool power-up
        if (!tif.guard_en || (tif.pwrup && !tif.over_temp)) begin
          state_nxt = AMP_RUN;
        end
      end
      default: state_nxt = AMP_RUN;
    endcase
  end

  // registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= AMP_RUN;
      evt_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      evt_r   <= evt_nxt;
    end
  end

  assign tif.amp_on   = (state_r == AMP_RUN);
  assign tif.shut_evt = evt_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_therm_trip;
    tif.amp_on && tif.guard_en && tif.over_temp |=> !tif.amp_on ##0 tif.shut_evt;
  endproperty
  a_therm_trip: assert property (p_therm_trip) else $error("no shutdown on heat"); // RL11

  property p_therm_hold;
    !tif.amp_on && tif.guard_en && !tif.pwrup |=> !tif.amp_on;
  endproperty
  a_therm_hold: assert property (p_therm_hold) else $error("amps woke unasked"); // RL12

  property p_therm_wake;
    !tif.amp_on && (!tif.guard_en || (tif.pwrup && !tif.over_temp)) |=> tif.amp_on;
  endproperty
  a_therm_wake: assert property (p_therm_wake) else $error("amps failed to wake"); // RL12

  c_therm_cycle: cover property (tif.shut_evt ##[1:50] tif.amp_on);

endmodule

// ### dac_toggle_ctrl.sv
// control core: a/b data registers, toggle, monitor mux, interrupts
//
// Contract
// (RL1) select 00 with channel address 001100 writes the control register
// (RL2) five control bits each enable toggling for one group of eight
// (RL3) every one of 40 channels holds an A and a B data register
// (RL4) B register loads are ignored unless that channel's group toggles
// (RL5) host enables groups, loads A, loads B, then strobes
// (RL6) each strobe swaps A and B; first strobe after enabling shows A
// (RL7) repeated strobes give a square wave at half the strobe rate
// (RL8) after toggling is disabled the next strobe loads from A
// (RL9) monitor enable first; then the last channel pin becomes monitor
// (RL10) selected channel goes to monitor; address 63 floats the pin
// (RL11) guard bit set: over-temperature powers all amplifiers down
// (RL12) amplifiers stay off until cool power-up or guard cleared
// (RL13) reset loads defaults and holds outputs at zero until a write
// (RL14) no toggling while the interface runs burst auto-increment mode
// (RL15) enable bit zero covers channels 0 to 7, rising upward
`timescale 1ns/1ns
module dac_toggle_ctrl
  import dac_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                       CLK,
  input  wire logic                       RST,
  // register port
  input  wire logic [SEL_W+CH_W-1:0]      ADDR,
  input  wire logic [CODE_W-1:0]          WDATA,
  input  wire logic                       WR,
  input  wire logic                       RD,
  output logic      [CODE_W-1:0]          RDATA,
  // interface mode and strobe
  input  wire logic                       BURST_MODE,
  input  wire logic                       OUTPUT_LOAD_STROBE_N,
  // thermal sense
  input  wire logic                       OVER_TEMP,
  // converter side
  output logic      [NUM_CH*CODE_W-1:0]   DAC_CODE,
  output logic                            OUT_HOLD_ZERO,
  output logic                            AMP_ON,
  // monitor
  output logic                            LAST_CHANNEL_OUTPUT_IS_MON,
  output logic      [CH_W-1:0]            MONITOR_OUTPUT_SEL,
  output logic                            MONITOR_OUTPUT_OE,
  // interrupt
  output logic                            IRQ
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // (RL15) group of a channel
  function automatic logic group_on(input logic [NUM_GROUPS-1:0] t,
                                    input int idx);
    return t[idx / GROUP_SZ];
  endfunction

  function automatic logic hit(input logic [SEL_W+CH_W-1:0] a,
                               input logic [SEL_W-1:0] s,
                               input logic [CH_W-1:0] c);
    return a == {s, c};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0][CODE_W-1:0] reg_a_r, reg_a_nxt;
  logic [NUM_CH-1:0][CODE_W-1:0] reg_b_r, reg_b_nxt;
  logic [NUM_CH-1:0][CODE_W-1:0] code_r, code_nxt;
  logic [NUM_CH-1:0]             ph_r, ph_nxt;
  logic [CODE_W-1:0]             ctrl_r, ctrl_nxt;
  logic [CH_W-1:0]               mon_sel_r, mon_sel_nxt;
  logic                          mon_oe_r, mon_oe_nxt;
  logic                          last_mon_r, last_mon_nxt;
  logic [IRQ_W-1:0]              stat_r, stat_nxt;
  logic [IRQ_W-1:0]              mask_r, mask_nxt;
  logic                          irq_r, irq_nxt;
  logic [CODE_W-1:0]             rdata_r, rdata_nxt;
  logic                          hold_r, hold_nxt;
  logic                          pwrup_r, pwrup_nxt;
  logic                          strobe_q_r;

  logic [SEL_W-1:0]              sel;
  logic [CH_W-1:0]               ch;
  logic                          in_range;
  logic [NUM_GROUPS-1:0]         tog_en;
  logic                          strobe_fire;
  logic                          b_rej;

  thermal_if tif ();

  thermal_guard u_guard (
    .clk (CLK),
    .rst (RST),
    .tif (tif)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign sel      = ADDR[SEL_W+CH_W-1:CH_W];
  assign ch       = ADDR[CH_W-1:0];
  assign in_range = ch < CH_LIMIT;
  // (RL2) group enables, (RL14) burst mode blocks
  assign tog_en   = BURST_MODE ? '0 : ctrl_r[CR_TOG_HI:CR_TOG_LO];
  // strobe asserts on its falling edge
  assign strobe_fire = strobe_q_r && !OUTPUT_LOAD_STROBE_N;
  // (RL4) refused B load
  assign b_rej = WR && sel == SEL_B && in_range && !group_on(tog_en, int'(ch));

  assign tif.guard_en  = ctrl_r[CR_THERM];
  assign tif.over_temp = OVER_TEMP;
  assign tif.pwrup     = pwrup_r;

  // ----------------------------------------------------------------
  // channel data path
  // ----------------------------------------------------------------
  always_comb begin
    reg_a_nxt = reg_a_r;
    reg_b_nxt = reg_b_r;
    code_nxt  = code_r;
    ph_nxt    = ph_r;
    for (int i = 0; i < NUM_CH; i++) begin
      // (RL3) A load
      if (WR && hit(ADDR, SEL_A, CH_W'(i))) begin
        reg_a_nxt[i] = WDATA;
      end
      // (RL4) B load gated
      if (WR && hit(ADDR, SEL_B, CH_W'(i)) && group_on(tog_en, i)) begin
        reg_b_nxt[i] = WDATA;
      end
      // (RL6) phase cleared while off, so first strobe shows A
      if (!group_on(tog_en, i)) begin
        ph_nxt[i] = 1'b0;
      end
      if (strobe_fire) begin
        if (group_on(tog_en, i)) begin
          // (RL7) alternate each strobe
          code_nxt[i] = ph_r[i] ? reg_b_r[i] : reg_a_r[i];
          ph_nxt[i]   = !ph_r[i];
        end else begin
          // (RL8) untoggled load from A
          code_nxt[i] = reg_a_r[i];
        end
      end
    end
  end

  // the strobe edge is taken against the previous sample, pin is synchronous
  always_ff @(posedge CLK) begin
    if (RST) begin
      // (RL13) defaults and zero outputs
      reg_a_r    <= '0;
      reg_b_r    <= '0;
      code_r     <= '0;
      ph_r       <= '0;
      strobe_q_r <= 1'b1;
    end else begin
      reg_a_r    <= reg_a_nxt;
      reg_b_r    <= reg_b_nxt;
      code_r     <= code_nxt;
      ph_r       <= ph_nxt;
      strobe_q_r <= OUTPUT_LOAD_STROBE_N;
    end
  end

  // ----------------------------------------------------------------
  // control, monitor, interrupt and read-back
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_nxt    = ctrl_r;
    mon_sel_nxt = mon_sel_r;
    mask_nxt    = mask_r;
    stat_nxt    = stat_r;
    hold_nxt    = hold_r && !WR;
    pwrup_nxt   = WR && hit(ADDR, SEL_CTRL, ADDR_PWRUP);
    rdata_nxt   = '0;
    // (RL1) control register write
    if (WR && hit(ADDR, SEL_CTRL, ADDR_CTRL)) begin
      ctrl_nxt = WDATA;
    end
    // (RL10) routing only accepted once monitoring is on
    if (WR && hit(ADDR, SEL_CTRL, ADDR_MON) && ctrl_r[CR_MON]) begin
      mon_sel_nxt = WDATA[CH_W-1:0];
    end
    if (!ctrl_nxt[CR_MON]) begin
      mon_sel_nxt = MON_OFF;
    end
    if (WR && hit(ADDR, SEL_CTRL, ADDR_MASK)) begin
      mask_nxt = WDATA[IRQ_W-1:0];
    end
    // write one clears, a same-cycle event wins
    if (WR && hit(ADDR, SEL_CTRL, ADDR_STAT)) begin
      stat_nxt = stat_nxt & ~WDATA[IRQ_W-1:0];
    end
    if (tif.shut_evt) begin
      stat_nxt[IRQ_THERM] = 1'b1;
    end
    if (b_rej) begin
      stat_nxt[IRQ_BREJ] = 1'b1;
    end
    // (RL9) last pin turns monitor
    last_mon_nxt = ctrl_nxt[CR_MON];
    // (RL10) address 63 floats the monitor pin
    mon_oe_nxt = ctrl_nxt[CR_MON] && mon_sel_nxt != MON_OFF;
    irq_nxt    = |(stat_nxt & mask_nxt);
    if (RD) begin
      unique case (sel)
        SEL_A: rdata_nxt = in_range ? reg_a_r[ch] : '0;
        SEL_B: rdata_nxt = in_range ? reg_b_r[ch] : '0;
        SEL_CTRL: begin
          if (ch == ADDR_CTRL) rdata_nxt = ctrl_r;
          if (ch == ADDR_MON)  rdata_nxt = {{(CODE_W-CH_W){1'b0}}, mon_sel_r};
          if (ch == ADDR_STAT) rdata_nxt = {{(CODE_W-IRQ_W){1'b0}}, stat_r};
          if (ch == ADDR_MASK) rdata_nxt = {{(CODE_W-IRQ_W){1'b0}}, mask_r};
        end
        default: rdata_nxt = '0;
      endcase
    end
  end

  // register the control group
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_r     <= CTRL_RST;
      mon_sel_r  <= MON_OFF;
      mon_oe_r   <= 1'b0;
      last_mon_r <= 1'b0;
      stat_r     <= '0;
      mask_r     <= MASK_RST;
      irq_r      <= 1'b0;
      rdata_r    <= '0;
      hold_r     <= 1'b1;
      pwrup_r    <= 1'b0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      mon_sel_r  <= mon_sel_nxt;
      mon_oe_r   <= mon_oe_nxt;
      last_mon_r <= last_mon_nxt;
      stat_r     <= stat_nxt;
      mask_r     <= mask_nxt;
      irq_r      <= irq_nxt;
      rdata_r    <= rdata_nxt;
      hold_r     <= hold_nxt;
      pwrup_r    <= pwrup_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign DAC_CODE                   = code_r;
  assign OUT_HOLD_ZERO              = hold_r;
  assign AMP_ON                     = tif.amp_on;
  assign LAST_CHANNEL_OUTPUT_IS_MON = last_mon_r;
  assign MONITOR_OUTPUT_SEL         = mon_sel_r;
  assign MONITOR_OUTPUT_OE          = mon_oe_r;
  assign IRQ                        = irq_r;
  assign RDATA                      = rdata_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_ctrl_wr;
    WR && ADDR == {SEL_CTRL, ADDR_CTRL} |=> ctrl_r == $past(WDATA);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost"); // RL1

  property p_grp_en;
    strobe_fire && !BURST_MODE && ctrl_r[CR_TOG_HI] |=> ph_r[NUM_CH-1] != $past(ph_r[NUM_CH-1]);
  endproperty
  a_grp_en: assert property (p_grp_en) else $error("group enable mismatch"); // RL2

  property p_a_load;
    WR && sel == SEL_A && in_range |=> reg_a_r[$past(ch)] == $past(WDATA);
  endproperty
  a_a_load: assert property (p_a_load) else $error("A load lost"); // RL3

  property p_b_gate;
    b_rej |=> $stable(reg_b_r);
  endproperty
  a_b_gate: assert property (p_b_gate) else $error("B loaded while off"); // RL4

  property p_first_a;
    strobe_fire && tog_en[0] && !ph_r[0] |=> code_r[0] == $past(reg_a_r[0]) && ph_r[0];
  endproperty
  a_first_a: assert property (p_first_a) else $error("first strobe not A"); // RL6

  property p_square;
    strobe_fire && tog_en[0] && ph_r[0] |=> code_r[0] == $past(reg_b_r[0]) && !ph_r[0];
  endproperty
  a_square: assert property (p_square) else $error("toggle did not swap"); // RL7

  property p_off_a;
    strobe_fire && !tog_en[NUM_GROUPS-1] |=> code_r[NUM_CH-1] == $past(reg_a_r[NUM_CH-1]);
  endproperty
  a_off_a: assert property (p_off_a) else $error("untoggled strobe not A"); // RL8

  property p_mon_pin;
    WR && ADDR == {SEL_CTRL, ADDR_CTRL} && WDATA[CR_MON] |=> LAST_CHANNEL_OUTPUT_IS_MON;
  endproperty
  a_mon_pin: assert property (p_mon_pin) else $error("monitor pin not taken"); // RL9

  property p_mon_float;
    WR && ADDR == {SEL_CTRL, ADDR_MON} && WDATA[CH_W-1:0] == MON_OFF |=> !MONITOR_OUTPUT_OE;
  endproperty
  a_mon_float: assert property (p_mon_float) else $error("monitor not floated"); // RL10

  property p_burst;
    BURST_MODE |=> ph_r == '0;
  endproperty
  a_burst: assert property (p_burst) else $error("toggle in burst mode"); // RL14

  property p_rst_zero;
    disable iff (1'b0) RST |=> code_r == '0 && OUT_HOLD_ZERO;
  endproperty
  a_rst_zero: assert property (p_rst_zero) else $error("reset not zero"); // RL13

  property p_hold_drop;
    WR |=> !OUT_HOLD_ZERO;
  endproperty
  a_hold_drop: assert property (p_hold_drop) else $error("hold not released"); // RL13

  c_toggle: cover property (strobe_fire && tog_en[0] ##[1:20] strobe_fire && tog_en[0]);
  c_b_rej:  cover property (b_rej);
  c_mon:    cover property (MONITOR_OUTPUT_OE);
  c_irq:    cover property (IRQ);

endmodule

// ### host_model.sv
// host controller model: register port, load strobe, mode and sense lines
`timescale 1ns/1ns
module host_model
  import dac_ctrl_pkg::*;
(
  // clock
  input  wire logic                   clk,
  // register port
  output logic      [SEL_W+CH_W-1:0]  addr,
  output logic      [CODE_W-1:0]      wdata,
  output logic                        wr,
  output logic                        rd,
  input  wire logic [CODE_W-1:0]      rdata,
  // mode, strobe and sense
  output logic                        burst_mode,
  output logic                        load_strobe_n,
  output logic                        over_temp
);
  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  // strobe idles high, sense cool, bus quiet
  initial begin
    addr          = '0;
    wdata         = '0;
    wr            = 1'b0;
    rd            = 1'b0;
    burst_mode    = 1'b0;
    load_strobe_n = 1'b1;
    over_temp     = 1'b0;
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  // one-cycle write; afterwards the bus shows junk, never the last value
  // soft power-up is a plain write
  task automatic write(input logic [SEL_W-1:0] s, input logic [CH_W-1:0] c,
                       input logic [CODE_W-1:0] d);
    @(posedge clk);
    addr  <= {s, c};
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    addr  <= ~addr;
    wdata <= ~wdata;
  endtask

  // one-cycle read; data taken in the cycle after the strobe
  task automatic read(input logic [SEL_W-1:0] s, input logic [CH_W-1:0] c,
                      output logic [CODE_W-1:0] d);
    @(posedge clk);
    addr <= {s, c};
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~addr;
    #1;
    d = rdata;
  endtask

  // strobe comes last
  // low for hold cycles, then high long enough to re-arm the edge detect
  task automatic strobe(input int hold);
    @(posedge clk);
    load_strobe_n <= 1'b0;
    repeat (hold) @(posedge clk);
    load_strobe_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // mode and sense lines change right after an edge, like the bus
  task automatic lines(input logic b, input logic t);
    @(posedge clk);
    burst_mode <= b;
    over_temp  <= t;
  endtask
endmodule

// ### tb.sv
// self-checking bench for the dac toggle, monitor and thermal control block
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin \
  total_checks++; \
  if ((got) !== (ex)) begin \
    $display("wrong value %s expected %h seen %h", nm, ex, got); \
    fail_count++; \
  end \
end
module tb
  import dac_ctrl_pkg::*;
;
  logic                      CLK;
  logic                      RST;
  logic [SEL_W+CH_W-1:0]     addr;
  logic [CODE_W-1:0]         wdata;
  logic                      wr;
  logic                      rd;
  logic [CODE_W-1:0]         RDATA;
  logic                      burst_mode;
  logic                      strobe_n;
  logic                      over_temp;
  logic [NUM_CH*CODE_W-1:0]  DAC_CODE;
  logic                      OUT_HOLD_ZERO;
  logic                      AMP_ON;
  logic                      is_mon;
  logic [CH_W-1:0]           mon_sel;
  logic                      mon_oe;
  logic                      IRQ;
  logic [CODE_W-1:0]         d;
  int                        fail_count = 0;
  int                        total_checks = 0;

  // ----------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------
  host_model host_model_inst (.clk(CLK), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(RDATA), .burst_mode(burst_mode), .load_strobe_n(strobe_n),
    .over_temp(over_temp));

  dac_toggle_ctrl dac_toggle_ctrl_inst (.CLK(CLK), .RST(RST), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(RDATA), .BURST_MODE(burst_mode),
    .OUTPUT_LOAD_STROBE_N(strobe_n), .OVER_TEMP(over_temp), .DAC_CODE(DAC_CODE),
    .OUT_HOLD_ZERO(OUT_HOLD_ZERO), .AMP_ON(AMP_ON), .LAST_CHANNEL_OUTPUT_IS_MON(is_mon),
    .MONITOR_OUTPUT_SEL(mon_sel), .MONITOR_OUTPUT_OE(mon_oe), .IRQ(IRQ));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // 25 MHz clock
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  function automatic logic [CODE_W-1:0] code(input int ch);
    return DAC_CODE[CODE_W*ch +: CODE_W];
  endfunction

  // registered outputs may lag a write by a cycle or two
  task automatic settle();
    repeat (3) @(posedge CLK);
    #1;
  endtask

  // bounded wait on the amplifier state; running out ends the run
  task automatic wait_amp(input logic v);
    int n;
    n = 0;
    while (AMP_ON !== v && n < 20) begin
      @(posedge CLK);
      #1;
      n++;
    end
    if (AMP_ON !== v) begin
      $display("wrong value amp_on expected %h seen %h", v, AMP_ON);
      fail_count++;
      stop_test();
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    RST = 1'b1;
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    #1;
    `CHK("code0", 14'h0000, code(0))
    `CHK("hold", 1'b1, OUT_HOLD_ZERO)
    `CHK("mon_oe", 1'b0, mon_oe)
    `CHK("mon_sel", MON_OFF, mon_sel)
    // b load refused while no group toggles
    host_model_inst.write(SEL_A, 6'h00, 14'h0111);
    settle();
    `CHK("hold", 1'b0, OUT_HOLD_ZERO)
    host_model_inst.write(SEL_B, 6'h00, 14'h0222);
    host_model_inst.read(SEL_B, 6'h00, d);
    `CHK("b0", 14'h0000, d)
    host_model_inst.read(SEL_CTRL, ADDR_STAT, d);
    `CHK("stat", 14'h0002, d)
    `CHK("irq", 1'b0, IRQ)
    host_model_inst.write(SEL_CTRL, ADDR_MASK, 14'h0002);
    settle();
    `CHK("irq", 1'b1, IRQ)
    host_model_inst.write(SEL_CTRL, ADDR_STAT, 14'h0002);
    settle();
    `CHK("irq", 1'b0, IRQ)
    // neighbour address is not the control register
    host_model_inst.write(SEL_CTRL, 6'h0b, 14'h0044);
    host_model_inst.read(SEL_CTRL, ADDR_CTRL, d);
    `CHK("ctrl", 14'h0000, d)
    host_model_inst.read(SEL_CTRL, 6'h0b, d);
    `CHK("unmapped", 14'h0000, d)
    // groups 0 and 4 toggle, group 1 does not
    host_model_inst.write(SEL_CTRL, ADDR_CTRL, 14'h0044);
    host_model_inst.read(SEL_CTRL, ADDR_CTRL, d);
    `CHK("ctrl", 14'h0044, d)
    host_model_inst.write(SEL_A, 6'h08, 14'h0333);
    host_model_inst.write(SEL_A, 6'h27, 14'h0555);
    host_model_inst.write(SEL_B, 6'h00, 14'h0222);
    host_model_inst.write(SEL_B, 6'h08, 14'h0444);
    host_model_inst.write(SEL_B, 6'h27, 14'h0666);
    host_model_inst.read(SEL_CTRL, ADDR_STAT, d);
    `CHK("stat", 14'h0002, d)
    host_model_inst.read(SEL_B, 6'h27, d);
    `CHK("b39", 14'h0666, d)
    host_model_inst.read(SEL_A, 6'h08, d);
    `CHK("a8", 14'h0333, d)
    host_model_inst.write(SEL_CTRL, ADDR_STAT, 14'h0002);
    // held-low strobes of growing length still count once each
    for (int k = 0; k < 4; k++) begin
      host_model_inst.strobe(k + 1);
      `CHK("code0", (k % 2 == 0) ? 14'h0111 : 14'h0222, code(0))
      `CHK("code39", (k % 2 == 0) ? 14'h0555 : 14'h0666, code(39))
      `CHK("code8", 14'h0333, code(8))
    end
    // burst mode blocks toggling; afterwards the phase starts at a again
    host_model_inst.lines(1'b1, 1'b0);
    for (int k = 0; k < 2; k++) begin
      host_model_inst.strobe(1);
      `CHK("burst0", 14'h0111, code(0))
    end
    host_model_inst.lines(1'b0, 1'b0);
    for (int k = 0; k < 2; k++) begin
      host_model_inst.strobe(1);
      `CHK("after0", (k == 0) ? 14'h0111 : 14'h0222, code(0))
    end
    host_model_inst.write(SEL_CTRL, ADDR_CTRL, 14'h0000);
    host_model_inst.strobe(1);
    `CHK("off0", 14'h0111, code(0))
    `CHK("off39", 14'h0555, code(39))
    // monitor select ignored until enabled
    host_model_inst.write(SEL_CTRL, ADDR_MON, 14'h0005);
    settle();
    `CHK("mon_sel", MON_OFF, mon_sel)
    `CHK("is_mon", 1'b0, is_mon)
    host_model_inst.write(SEL_CTRL, ADDR_CTRL, 14'h0200);
    host_model_inst.write(SEL_CTRL, ADDR_MON, 14'h0005);
    settle();
    `CHK("is_mon", 1'b1, is_mon)
    `CHK("mon_sel", 6'h05, mon_sel)
    `CHK("mon_oe", 1'b1, mon_oe)
    host_model_inst.write(SEL_CTRL, ADDR_MON, {8'h00, MON_OFF});
    settle();
    `CHK("mon_oe", 1'b0, mon_oe)
    // thermal shutdown, refused hot power-up, cool power-up
    host_model_inst.write(SEL_CTRL, ADDR_MASK, 14'h0001);
    host_model_inst.write(SEL_CTRL, ADDR_CTRL, 14'h0300);
    host_model_inst.lines(1'b0, 1'b1);
    wait_amp(1'b0);
    settle();
    `CHK("irq", 1'b1, IRQ)
    host_model_inst.write(SEL_CTRL, ADDR_PWRUP, 14'h0000);
    settle();
    `CHK("amp", 1'b0, AMP_ON)
    host_model_inst.lines(1'b0, 1'b0);
    host_model_inst.write(SEL_CTRL, ADDR_PWRUP, 14'h0000);
    settle();
    `CHK("amp", 1'b1, AMP_ON)
    host_model_inst.write(SEL_CTRL, ADDR_STAT, 14'h0001);
    settle();
    `CHK("irq", 1'b0, IRQ)
    host_model_inst.lines(1'b0, 1'b1);
    wait_amp(1'b0);
    host_model_inst.write(SEL_CTRL, ADDR_CTRL, 14'h0200);
    settle();
    `CHK("amp", 1'b1, AMP_ON)
    settle();
    `CHK("amp", 1'b1, AMP_ON)
    host_model_inst.lines(1'b0, 1'b0);
    stop_test();
  end
endmodule
